// [logic/pio_filter.sv]
// Glitch filter and edge detector for one port input.
// Input is synchronous to the clock; a level must hold for PULSE_CYC cycles to be accepted.
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_filter #(
   parameter int PULSE_CYC = `PIO_MIN_PULSE_CYC
) (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable.
   input wire logic din, // Raw input pin.
   output pio_pkg::pio_edge_type edge_o // Filtered level and one-cycle edge pulses.
);
   localparam int CW = $clog2(PULSE_CYC + 1);
   logic sync1_q;
   logic sync2_q;
   logic stable_q;
   logic [CW-1:0] cnt_q;

   // Inputs idle high through pull-ups, so reset to high avoids a false edge.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= 1'h1;
         sync2_q <= 1'h1;
      end
      else if (ce)
      begin
         sync1_q <= din;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stable_q <= 1'h1;
         cnt_q <= '0;
         edge_o <= '{rise: 1'h0, fall: 1'h0, level: 1'h1};
      end
      else if (ce)
      begin
         edge_o.rise <= 1'h0;
         edge_o.fall <= 1'h0;
         if (sync2_q == stable_q)
         begin
            cnt_q <= '0;
         end
         else if (cnt_q == CW'(PULSE_CYC - 1))
         begin
            cnt_q <= '0;
            stable_q <= sync2_q;
            edge_o.rise <= sync2_q;
            edge_o.fall <= ~sync2_q;
         end
         else
         begin
            cnt_q <= cnt_q + CW'(1);
         end
         edge_o.level <= stable_q;
      end
   end
endmodule

// [logic/pio_params.svh]
// Timing, reset and encoding constants for the pump user I/O port.
// Included by the design modules, not by the package; holds definitions only.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_CLK_HZ 10000000
`define PIO_MIN_PULSE_MS 100
`define PIO_ANALOG_CYCLE_MS 100
`define PIO_SETTLE_MS 250
`define PIO_MIN_PULSE_CYC ((`PIO_CLK_HZ / 1000) * `PIO_MIN_PULSE_MS)
`define PIO_ANALOG_CYCLE_CYC ((`PIO_CLK_HZ / 1000) * `PIO_ANALOG_CYCLE_MS)
`define PIO_DEF_CHAIN_ADDR 7'h01
`define PIO_FS_TOGGLE 2'h0
`define PIO_FS_RISE_START 2'h1
`define PIO_FS_FALL_START 2'h2
`define PIO_VALVE_MANUAL 1'h0
`define PIO_VALVE_AUTO 1'h1
`endif

// [logic/pio_pkg.sv]
// Types shared by the pump user I/O port modules.
// Constants live in pio_params.svh.
package pio_pkg;
   typedef enum logic [2:0] {
      PIO_ST_IDLE = 3'b001,
      PIO_ST_INFUSE = 3'b010,
      PIO_ST_REFILL = 3'b100
   } pio_phase_type;

   typedef struct packed {
      logic rise;
      logic fall;
      logic level;
   } pio_edge_type;

   typedef struct packed {
      logic trig1;
      logic trig2;
      logic sync;
      logic dir;
      logic valve;
      logic run_n;
   } pio_out_type;
endpackage

// [logic/pio_port.sv]
// Pump user I/O port: input edge decoding, output drivers and analog rate sampling.
// Assumes one 10 MHz system clock, synchronous inputs, and a pump core that consumes
// the command pulses and reports motion and phase changes.
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_port #(
   parameter int PULSE_CYC = `PIO_MIN_PULSE_CYC,
   parameter int ANALOG_CYC = `PIO_ANALOG_CYCLE_CYC,
   parameter int RATE_W = 12,
   parameter int ADDR_W = 7
) (
   input wire logic CLK_SYS, // System clock, 10 MHz.
   input wire logic SYS_RST, // Synchronous reset, active high.
   input wire logic CE, // Clock enable; low freezes all state.
   input wire logic DIR_IN, // Direction control input pin.
   input wire logic EVT_IN, // Event trigger input pin.
   input wire logic FSW_IN, // Footswitch input pin.
   input wire logic [1:0] FSW_MODE, // Footswitch mode select.
   input wire logic VALVE_AUTO, // Valve toggles on each core direction change when high.
   input wire logic VALVE_SET, // Manual valve level pulse strobe.
   input wire logic VALVE_VAL, // Manual valve level.
   input wire logic TRIG_WR, // Method or serial write strobe for trigger outputs.
   input wire logic [1:0] TRIG_VAL, // Trigger output levels: bit 0 trigger 1, bit 1 trigger 2.
   input wire logic CORE_RUNNING, // Pump motor is running.
   input wire logic CORE_DIR_SET, // Core direction change pulse.
   input wire logic CORE_DIR_REFILL, // Direction requested by core, high for refill.
   input wire logic PHASE_START, // Core starts a motion phase, one-cycle pulse.
   input wire logic ANALOG_MODE, // Analog rate control mode enable.
   input wire logic [RATE_W-1:0] ANALOG_RATE, // Digitised analog rate input.
   input wire logic ADDR_WR, // Chain command address write strobe.
   input wire logic [ADDR_W-1:0] ADDR_VAL, // New chain address.
   output logic CMD_INFUSE, // Pulse: switch pump to infuse.
   output logic CMD_REFILL, // Pulse: switch pump to refill.
   output logic CMD_EVENT, // Pulse: program event for the method sequence.
   output logic CMD_RUN, // Pulse: start the pump.
   output logic CMD_STOP, // Pulse: stop the pump.
   output logic TRIG1_OUT, // Trigger 1 output pin.
   output logic TRIG2_OUT, // Trigger 2 output pin.
   output logic SYNC_OUT, // Sync output pin.
   output logic DIR_OUT, // Direction output pin, high for refill.
   output logic VALVE_OUT, // Valve output pin.
   output logic RUN_N_OUT, // Run indicator, low while running.
   output logic [RATE_W-1:0] RATE_OUT, // Sampled pump rate.
   output logic RATE_UPD, // Pulse: new rate sample taken.
   output logic [ADDR_W-1:0] CHAIN_ADDR // Current chain address.
);
   localparam int AW = $clog2(ANALOG_CYC + 1);
   pio_pkg::pio_edge_type dir_e;
   pio_pkg::pio_edge_type evt_e;
   pio_pkg::pio_edge_type fsw_e;
   pio_pkg::pio_out_type out_q;
   pio_pkg::pio_phase_type phase_q;
   logic refill_q;
   logic [AW-1:0] acnt_q;

   pio_filter #(.PULSE_CYC(PULSE_CYC)) u_dir (.clk(CLK_SYS), .rst(SYS_RST), .ce(CE), .din(DIR_IN), .edge_o(dir_e));
   pio_filter #(.PULSE_CYC(PULSE_CYC)) u_evt (.clk(CLK_SYS), .rst(SYS_RST), .ce(CE), .din(EVT_IN), .edge_o(evt_e));
   pio_filter #(.PULSE_CYC(PULSE_CYC)) u_fsw (.clk(CLK_SYS), .rst(SYS_RST), .ce(CE), .din(FSW_IN), .edge_o(fsw_e));

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         CMD_INFUSE <= 1'h0;
         CMD_REFILL <= 1'h0;
         CMD_EVENT <= 1'h0;
      end
      else if (CE)
      begin
         CMD_INFUSE <= dir_e.rise;
         CMD_REFILL <= dir_e.fall;
         CMD_EVENT <= evt_e.fall;
      end
   end

   // Toggle mode consults the running flag so it stays in step with other start sources.
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         CMD_RUN <= 1'h0;
         CMD_STOP <= 1'h0;
      end
      else if (CE)
      begin
         CMD_RUN <= 1'h0;
         CMD_STOP <= 1'h0;
         unique case (FSW_MODE)
            `PIO_FS_TOGGLE:
            begin
               CMD_RUN <= fsw_e.fall & ~CORE_RUNNING;
               CMD_STOP <= fsw_e.fall & CORE_RUNNING;
            end
            `PIO_FS_RISE_START:
            begin
               CMD_RUN <= fsw_e.rise;
               CMD_STOP <= fsw_e.fall;
            end
            `PIO_FS_FALL_START:
            begin
               CMD_RUN <= fsw_e.fall;
               CMD_STOP <= fsw_e.rise;
            end
            default:
            begin
               CMD_RUN <= 1'h0;
               CMD_STOP <= 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         out_q.trig1 <= 1'h0;
         out_q.trig2 <= 1'h0;
      end
      else if (CE && TRIG_WR)
      begin
         out_q.trig1 <= TRIG_VAL[0];
         out_q.trig2 <= TRIG_VAL[1];
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         refill_q <= 1'h0;
      end
      else if (CE && CORE_DIR_SET)
      begin
         refill_q <= CORE_DIR_REFILL;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         phase_q <= pio_pkg::PIO_ST_IDLE;
         out_q.sync <= 1'h0;
      end
      else if (CE && PHASE_START)
      begin
         unique case (refill_q)
            1'h0:
            begin
               phase_q <= pio_pkg::PIO_ST_INFUSE;
               out_q.sync <= 1'h1;
            end
            1'h1:
            begin
               phase_q <= pio_pkg::PIO_ST_REFILL;
               out_q.sync <= 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         out_q.dir <= 1'h0;
         out_q.run_n <= 1'h1;
      end
      else if (CE)
      begin
         out_q.dir <= refill_q;
         out_q.run_n <= ~CORE_RUNNING;
      end
   end

   // A manual write wins over an automatic toggle in the same cycle.
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         out_q.valve <= 1'h0;
      end
      else if (CE)
      begin
         if (VALVE_SET)
         begin
            out_q.valve <= VALVE_VAL;
         end
         else if (VALVE_AUTO == `PIO_VALVE_AUTO && CORE_DIR_SET && CORE_DIR_REFILL != refill_q)
         begin
            out_q.valve <= ~out_q.valve;
         end
      end
   end

   // The rate is only ever taken at the cycle boundary; a settle delay beyond that is the source's duty.
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         acnt_q <= '0;
         RATE_OUT <= '0;
         RATE_UPD <= 1'h0;
      end
      else if (CE)
      begin
         RATE_UPD <= 1'h0;
         if (!ANALOG_MODE)
         begin
            acnt_q <= '0;
         end
         else if (acnt_q == AW'(ANALOG_CYC - 1))
         begin
            acnt_q <= '0;
            RATE_OUT <= ANALOG_RATE;
            RATE_UPD <= 1'h1;
         end
         else
         begin
            acnt_q <= acnt_q + AW'(1);
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         CHAIN_ADDR <= ADDR_W'(`PIO_DEF_CHAIN_ADDR);
      end
      else if (CE && ADDR_WR)
      begin
         CHAIN_ADDR <= ADDR_VAL;
      end
   end

   assign TRIG1_OUT = out_q.trig1;
   assign TRIG2_OUT = out_q.trig2;
   assign SYNC_OUT = out_q.sync;
   assign DIR_OUT = out_q.dir;
   assign VALVE_OUT = out_q.valve;
   assign RUN_N_OUT = out_q.run_n;
endmodule

// [verif/pio_ext_model.sv]
// Model of the external TTL equipment on the user I/O pins.
// The bench sets request levels; the pins follow on the falling clock edge.
`timescale 1ns/1ps
module pio_ext_model (
   input wire logic clk, // System clock.
   input wire logic [2:0] pin_req, // Wanted levels: direction, event, footswitch.
   input wire logic an_en, // Analog source enabled.
   input wire logic [11:0] an_req, // Wanted analog rate.
   output logic dir_pin, // Direction pin.
   output logic evt_pin, // Event pin.
   output logic fsw_pin, // Footswitch pin.
   output logic [11:0] an_rate // Rate seen by the port.
);
   initial {dir_pin, evt_pin, fsw_pin, an_rate} = 15'h7000;
   always @(negedge clk)
   begin
      {dir_pin, evt_pin, fsw_pin} <= pin_req;
      // The source sits at zero until enabled, so power-on never sees a stray rate.
      an_rate <= an_en ? an_req : 12'h000;
   end
endmodule

// [verif/pio_port_chk.sv]
// Concurrent checks on the pins of the pump user I/O port, bound into every pio_port.
// Assumes the bench spaces core strobes a few cycles apart and keeps CE high.
`timescale 1ns/1ps
module pio_port_chk #(
   parameter int RATE_W = 12,
   parameter int ADDR_W = 7
) (
   input wire logic CLK_SYS, SYS_RST, CE, DIR_IN, EVT_IN, VALVE_AUTO, VALVE_SET, VALVE_VAL, // Clock and controls.
   input wire logic TRIG_WR, CORE_RUNNING, CORE_DIR_SET, CORE_DIR_REFILL, PHASE_START, ADDR_WR, // Strobes.
   input wire logic [1:0] TRIG_VAL, // Trigger levels.
   input wire logic [RATE_W-1:0] ANALOG_RATE, RATE_OUT, // Rate in and out.
   input wire logic [ADDR_W-1:0] ADDR_VAL, CHAIN_ADDR, // Chain address.
   input wire logic CMD_INFUSE, CMD_EVENT, TRIG1_OUT, TRIG2_OUT, SYNC_OUT, // Outputs.
   input wire logic DIR_OUT, VALVE_OUT, RUN_N_OUT, RATE_UPD // Outputs.
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   sequence s_dir; CE && CORE_DIR_SET; endsequence
   sequence s_quiet; !RATE_UPD [*7]; endsequence
   // The reset check must run while reset is high, so it drops the default disable.
   property p_rst; disable iff (1'b0) SYS_RST |=> !TRIG1_OUT && !TRIG2_OUT && RUN_N_OUT && CHAIN_ADDR == 1; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_trig; CE && TRIG_WR |=> {TRIG2_OUT, TRIG1_OUT} == $past(TRIG_VAL); endproperty
   a_trig: assert property (p_trig) else $error("trigger write lost");
   property p_trig_hold; !TRIG_WR |=> $stable({TRIG2_OUT, TRIG1_OUT}); endproperty
   a_trig_hold: assert property (p_trig_hold) else $error("trigger moved unasked");
   property p_dir; s_dir |-> ##2 DIR_OUT == $past(CORE_DIR_REFILL, 2); endproperty
   a_dir: assert property (p_dir) else $error("direction output wrong");
   property p_sync; CE && PHASE_START |=> SYNC_OUT == !$past(DIR_OUT); endproperty
   a_sync: assert property (p_sync) else $error("sync level wrong");
   property p_run; CE |=> RUN_N_OUT == !$past(CORE_RUNNING); endproperty
   a_run: assert property (p_run) else $error("run indicator wrong");
   property p_vman; CE && VALVE_SET |=> VALVE_OUT == $past(VALVE_VAL); endproperty
   a_vman: assert property (p_vman) else $error("manual valve wrong");
   property p_vauto; s_dir ##0 (VALVE_AUTO && !VALVE_SET && CORE_DIR_REFILL != DIR_OUT) |=> $changed(VALVE_OUT); endproperty
   a_vauto: assert property (p_vauto) else $error("auto valve missed");
   property p_rate; RATE_UPD |-> RATE_OUT == $past(ANALOG_RATE) ##1 s_quiet; endproperty
   a_rate: assert property (p_rate) else $error("rate sample wrong");
   property p_addr; CE && ADDR_WR |=> CHAIN_ADDR == $past(ADDR_VAL); endproperty
   a_addr: assert property (p_addr) else $error("chain address wrong");
   property p_inf; CMD_INFUSE |-> $past(DIR_IN, 3) && $past(DIR_IN, 4) ##1 !CMD_INFUSE; endproperty
   a_inf: assert property (p_inf) else $error("infuse without high input");
   property p_evt; CMD_EVENT |-> !$past(EVT_IN, 3) && !$past(EVT_IN, 4); endproperty
   a_evt: assert property (p_evt) else $error("event without low input");
endmodule
bind pio_port pio_port_chk #(.RATE_W(RATE_W), .ADDR_W(ADDR_W)) u_chk (.*);

// [verif/test_pump_user_io_port.sv]
// Self-checking bench for pio_port with short filter and analog counts.
// Uses pio_ext_model for the pins; the bound checker watches the ports.
`timescale 1ns/1ps
module test_pump_user_io_port;
   localparam int PC = 4;
   logic CLK_SYS = 1'h0, SYS_RST = 1'h1, CE = 1'h1, VALVE_AUTO = 1'h0, VALVE_SET = 1'h0, VALVE_VAL = 1'h0;
   logic TRIG_WR = 1'h0, CORE_RUNNING = 1'h0, CORE_DIR_SET = 1'h0, CORE_DIR_REFILL = 1'h0, PHASE_START = 1'h0;
   logic ANALOG_MODE = 1'h0, ADDR_WR = 1'h0, an_en = 1'h0, ev;
   logic [1:0] FSW_MODE = 2'h3, TRIG_VAL = 2'h0;
   logic [6:0] ADDR_VAL = 7'h00, CHAIN_ADDR;
   logic [11:0] an_req = 12'h000, ANALOG_RATE, RATE_OUT;
   logic [2:0] pin_req = 3'h7;
   logic [15:0] lfsr = 16'h0018;
   logic DIR_IN, EVT_IN, FSW_IN, CMD_INFUSE, CMD_REFILL, CMD_EVENT, CMD_RUN, CMD_STOP;
   logic TRIG1_OUT, TRIG2_OUT, SYNC_OUT, DIR_OUT, VALVE_OUT, RUN_N_OUT, RATE_UPD;
   int err_count = 0, tests_run = 0, cyc = 0, k;
   int cnt[5] = '{0, 0, 0, 0, 0};
   logic [4:0] cmd_v;
   assign cmd_v = {CMD_STOP, CMD_RUN, CMD_EVENT, CMD_REFILL, CMD_INFUSE};
   pio_port #(.PULSE_CYC(PC), .ANALOG_CYC(8)) uut (.*);
   pio_ext_model ext (.clk(CLK_SYS), .pin_req(pin_req), .an_en(an_en), .an_req(an_req), .dir_pin(DIR_IN),
      .evt_pin(EVT_IN), .fsw_pin(FSW_IN), .an_rate(ANALOG_RATE));
   always #50 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS)
   begin
      cyc++;
      for (int i = 0; i < 5; i++) if (cmd_v[i] === 1'h1) cnt[i]++;
      if (cyc == 5000)
      begin
         err_count++;
         complete_run();
      end
   end
   function automatic logic [15:0] nxt(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Returns {stop, run} expected for a footswitch edge in the given mode.
   function automatic logic [1:0] fs_exp(logic [1:0] m, logic rising);
      case (m)
         2'h0: return rising ? 2'h0 : 2'h1;
         2'h1: return rising ? 2'h1 : 2'h2;
         2'h2: return rising ? 2'h2 : 2'h1;
         default: return 2'h0;
      endcase
   endfunction
   task automatic step(int n);
      repeat (n) @(negedge CLK_SYS);
   endtask
   task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Moves one pin, holds it past the filter and compares each command count.
   task automatic edge_chk(int p, logic v, logic [4:0] e);
      int b[5];
      b = cnt;
      pin_req[p] = v;
      step(PC + 10);
      for (int i = 0; i < 5; i++) chk("cmd", 12'(e[i]), 12'(cnt[i] - b[i]));
   endtask
   task automatic complete_run();
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      step(3);
      SYS_RST = 1'h0;
      step(1);
      chk("outs", 12'h000, {SYNC_OUT, DIR_OUT, VALVE_OUT, TRIG2_OUT, TRIG1_OUT});
      chk("run_n", 12'h001, RUN_N_OUT);
      chk("addr", 12'h001, CHAIN_ADDR);
      edge_chk(2, 1'h0, 5'h02);
      edge_chk(2, 1'h1, 5'h01);
      pin_req[2] = 1'h0;
      step(PC - 2);
      edge_chk(2, 1'h1, 5'h00);
      edge_chk(1, 1'h0, 5'h04);
      edge_chk(1, 1'h1, 5'h00);
      for (int m = 0; m < 4; m++)
      begin
         FSW_MODE = 2'(m);
         edge_chk(0, 1'h0, {fs_exp(FSW_MODE, 1'h0), 3'h0});
         edge_chk(0, 1'h1, {fs_exp(FSW_MODE, 1'h1), 3'h0});
      end
      FSW_MODE = 2'h0;
      CORE_RUNNING = 1'h1;
      edge_chk(0, 1'h0, 5'h10);
      chk("run_n", 12'h000, RUN_N_OUT);
      for (int j = 0; j < 20; j++)
      begin
         lfsr = nxt(lfsr);
         {TRIG_VAL, ADDR_VAL, VALVE_VAL, CORE_DIR_REFILL, VALVE_AUTO, CORE_RUNNING} = lfsr[12:0];
         {TRIG_WR, ADDR_WR, VALVE_SET} = 3'h7;
         step(1);
         {TRIG_WR, ADDR_WR, VALVE_SET} = 3'h0;
         chk("trig", 12'(TRIG_VAL), {TRIG2_OUT, TRIG1_OUT});
         chk("addr", 12'(ADDR_VAL), CHAIN_ADDR);
         chk("valve", 12'(VALVE_VAL), VALVE_OUT);
         chk("run_n", 12'(!CORE_RUNNING), RUN_N_OUT);
         ev = (VALVE_AUTO && CORE_DIR_REFILL != DIR_OUT) ? !VALVE_OUT : VALVE_OUT;
         CORE_DIR_SET = 1'h1;
         step(1);
         CORE_DIR_SET = 1'h0;
         step(1);
         chk("dir", 12'(CORE_DIR_REFILL), DIR_OUT);
         chk("valve", 12'(ev), VALVE_OUT);
         PHASE_START = 1'h1;
         step(1);
         PHASE_START = 1'h0;
         chk("sync", 12'(!CORE_DIR_REFILL), SYNC_OUT);
      end
      {ANALOG_MODE, an_en} = 2'h3;
      for (int j = 0; j < 3; j++)
      begin
         lfsr = nxt(lfsr);
         an_req = lfsr[11:0];
         // After the first sample one cycle of the period has already gone by in the trailing step.
         for (k = (j == 0) ? 1 : 2; k < 20 && RATE_UPD !== 1'h1; k++) step(1);
         chk("period", 12'h008, 12'(k - 1));
         chk("rate", an_req, RATE_OUT);
         step(1);
      end
      complete_run();
   end
endmodule
